/* hw/jip_pkg.sv */
// shared constants for the scan port device and its controller
package jip_pkg;
  localparam int IR_LEN  = 10;   // instruction length in bits
  localparam int ID_LEN  = 32;   // identification and signature length
  localparam int BSR_LEN = 192;  // boundary cells of the 64-pin part
  localparam int BSR_MIN = 96;   // smallest family chain
  localparam int BSR_MAX = 624;  // largest family chain

  // instruction codes
  localparam logic [9:0] IR_CAPTURE  = 10'h001;  // fixed capture pattern
  localparam logic [9:0] OP_EXTEST   = 10'h000;  // pins from boundary cells
  localparam logic [9:0] OP_SAMPLE   = 10'h055;  // snapshot pins
  localparam logic [9:0] OP_DEVICE_IDENTIFICATION   = 10'h059;  // identification word
  localparam logic [9:0] OP_USER_SIGNATURE = 10'h007;  // user signature word
  localparam logic [9:0] OP_ISP_EN   = 10'h2cc;  // enter programming
  localparam logic [9:0] OP_ISP_DIS  = 10'h201;  // leave programming
  localparam logic [9:0] OP_PROGRAMMING_COMPLETE_FLAG = 10'h2f0;  // program the done flag
  localparam logic [9:0] OP_ISP_ERA  = 10'h3f2;  // erase, clears done flag
  localparam logic [9:0] OP_BYPASS   = 10'h3ff;  // one-bit path

  // tap controller states
  typedef enum logic [3:0] {
    S_RESET, S_IDLE,
    S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } jip_tap_e;

  // controller register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;  // command
  localparam logic [3:0] REG_STAT = 4'h4;  // status
  localparam logic [3:0] REG_TX   = 4'h8;  // bits to shift in
  localparam logic [3:0] REG_RX   = 4'hc;  // bits shifted out
  localparam int CTL_KIND = 0;  // [1:0] operation kind
  localparam int CTL_LEN  = 2;  // [6:2] bit count minus one
  localparam int CTL_HOLD = 7;  // rest in pause after shift
  localparam int CTL_CONT = 8;  // resume from pause
  localparam logic [1:0] KIND_RESET = 2'h0;
  localparam logic [1:0] KIND_IR    = 2'h1;
  localparam logic [1:0] KIND_DR    = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // tms walks, lsb first, count in upper bits
  localparam logic [10:0] WALK_RESET = {3'h6, 8'h1f};  // 1,1,1,1,1,0
  localparam logic [10:0] WALK_IR    = {3'h4, 8'h03};  // 1,1,0,0
  localparam logic [10:0] WALK_DR    = {3'h3, 8'h01};  // 1,0,0
  localparam logic [10:0] WALK_CONT  = {3'h2, 8'h01};  // 1,0 from pause
  localparam logic [10:0] WALK_DONE  = {3'h2, 8'h01};  // update, idle
  localparam logic [10:0] WALK_HOLD  = {3'h1, 8'h00};  // to pause

  // link clock made by the controller
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCK_PERIOD_NS = 80;
  localparam int TCK_HALF_CYC  = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

/* hw/jip_link_if.sv */
// serial test link joining the controller and the device
`timescale 1ns/1ps
interface jip_link_if;
  logic tck;  // test clock, made by the controller
  logic tms;  // mode select
  logic tdi;  // serial data into the device
  logic tdo;  // serial data out of the device

  modport host (output tck, output tms, output tdi, input tdo);
  modport dev  (input tck, input tms, input tdi, output tdo);
endinterface

/* hw/jip_scan_dev.sv */
// scan port device end: tap, identification, boundary cells, programming gate
`timescale 1ns/1ps

module jip_scan_dev #(
  parameter logic [3:0]  ID_VER   = 4'h2,         // arbitrary value
  parameter logic [15:0] ID_PART  = 16'h5a3c,     // arbitrary value
  parameter logic [10:0] ID_MFR   = 11'h0aa,      // arbitrary value
  parameter logic [31:0] USER_SIG = 32'h0000_0000 // user signature word
) (
  jip_link_if.dev                                link,        // serial test port
  input  wire logic                              aresetn,     // sync reset on tck
  input  wire logic                              power_good,  // supplies in range
  input  wire logic [jip_pkg::BSR_LEN/3-1:0]     core_out,    // core pin values
  input  wire logic [jip_pkg::BSR_LEN/3-1:0]     core_oe,     // core pin enables
  input  wire logic [jip_pkg::BSR_LEN/3-1:0]     pin_i,       // pin levels
  output logic      [jip_pkg::BSR_LEN/3-1:0]     pin_o,       // pin drive value
  output logic      [jip_pkg::BSR_LEN/3-1:0]     pin_oe,      // pin drive enable
  output logic                                   pin_pullup,  // weak pull-ups on
  output logic                                   prog_done,   // done flag state
  output logic                                   isp_active   // programming mode
);
  localparam int NPINS = jip_pkg::BSR_LEN / 3;  // three cells per pin
  localparam int IRW   = jip_pkg::IR_LEN;
  localparam int BW    = jip_pkg::BSR_LEN;

  // whole state of the device end
  typedef struct packed {
    jip_pkg::jip_tap_e st;      // tap controller state
    logic [IRW-1:0]    ir;      // active instruction
    logic [IRW-1:0]    ir_sh;   // instruction shift path
    logic [BW-1:0]     dr;      // data shift path, longest chain
    logic [BW-1:0]     bsr;     // boundary update cells
    logic [NPINS-1:0]  pin_s1;  // pin sync, first stage
    logic [NPINS-1:0]  pin_s2;  // pin sync, second stage
    logic [1:0]        pg;      // power good sync
    logic              done;    // programming complete flag
    logic              in_system_programming;     // programming mode
  } jip_dev_s;

  jip_dev_s r;       // registered state
  jip_dev_s next_r;  // next state

  // chain length selected by an instruction
  function automatic logic [7:0] jip_dr_len(input logic [IRW-1:0] op);
    case (op)
      jip_pkg::OP_DEVICE_IDENTIFICATION, jip_pkg::OP_USER_SIGNATURE: return 8'(jip_pkg::ID_LEN);
      jip_pkg::OP_EXTEST, jip_pkg::OP_SAMPLE:   return 8'(BW);
      default:                                  return 8'h01;  // bypass path
    endcase
  endfunction

  // next state
  always_comb begin
    logic [BW-1:0] sh;
    int            len;
    sh = {1'b0, r.dr[BW-1:1]};
    len = int'(jip_dr_len(r.ir));
    next_r = r;
    next_r.pg = {r.pg[0], power_good};
    next_r.pin_s1 = pin_i;
    next_r.pin_s2 = r.pin_s1;

    // tap walk, one step per rising tck
    case (r.st)
      jip_pkg::S_RESET:  next_r.st = link.tms ? jip_pkg::S_RESET  : jip_pkg::S_IDLE;
      jip_pkg::S_IDLE:   next_r.st = link.tms ? jip_pkg::S_SEL_DR : jip_pkg::S_IDLE;
      jip_pkg::S_SEL_DR: next_r.st = link.tms ? jip_pkg::S_SEL_IR : jip_pkg::S_CAP_DR;
      jip_pkg::S_CAP_DR: next_r.st = link.tms ? jip_pkg::S_EX1_DR : jip_pkg::S_SH_DR;
      jip_pkg::S_SH_DR:  next_r.st = link.tms ? jip_pkg::S_EX1_DR : jip_pkg::S_SH_DR;
      jip_pkg::S_EX1_DR: next_r.st = link.tms ? jip_pkg::S_UPD_DR : jip_pkg::S_PA_DR;
      jip_pkg::S_PA_DR:  next_r.st = link.tms ? jip_pkg::S_EX2_DR : jip_pkg::S_PA_DR;
      jip_pkg::S_EX2_DR: next_r.st = link.tms ? jip_pkg::S_UPD_DR : jip_pkg::S_SH_DR;
      jip_pkg::S_UPD_DR: next_r.st = link.tms ? jip_pkg::S_SEL_DR : jip_pkg::S_IDLE;
      jip_pkg::S_SEL_IR: next_r.st = link.tms ? jip_pkg::S_RESET  : jip_pkg::S_CAP_IR;
      jip_pkg::S_CAP_IR: next_r.st = link.tms ? jip_pkg::S_EX1_IR : jip_pkg::S_SH_IR;
      jip_pkg::S_SH_IR:  next_r.st = link.tms ? jip_pkg::S_EX1_IR : jip_pkg::S_SH_IR;
      jip_pkg::S_EX1_IR: next_r.st = link.tms ? jip_pkg::S_UPD_IR : jip_pkg::S_PA_IR;
      jip_pkg::S_PA_IR:  next_r.st = link.tms ? jip_pkg::S_EX2_IR : jip_pkg::S_PA_IR;
      jip_pkg::S_EX2_IR: next_r.st = link.tms ? jip_pkg::S_UPD_IR : jip_pkg::S_SH_IR;
      jip_pkg::S_UPD_IR: next_r.st = link.tms ? jip_pkg::S_SEL_DR : jip_pkg::S_IDLE;
      default:           next_r.st = jip_pkg::S_RESET;
    endcase

    // actions of the current state
    case (r.st)
      jip_pkg::S_RESET: begin
        next_r.ir = jip_pkg::OP_DEVICE_IDENTIFICATION;  // identification after reset
      end
      jip_pkg::S_IDLE: begin
        // flag is the last step of a pass; an erase reopens the window
        if (r.in_system_programming && r.ir == jip_pkg::OP_PROGRAMMING_COMPLETE_FLAG) begin
          next_r.done = 1'b1;
        end
        if (r.in_system_programming && r.ir == jip_pkg::OP_ISP_ERA) begin
          next_r.done = 1'b0;
        end
      end
      jip_pkg::S_CAP_IR: begin
        next_r.ir_sh = jip_pkg::IR_CAPTURE;
      end
      jip_pkg::S_SH_IR: begin
        next_r.ir_sh = {link.tdi, r.ir_sh[IRW-1:1]};
      end
      jip_pkg::S_UPD_IR: begin
        next_r.ir = r.ir_sh;
        if (r.ir_sh == jip_pkg::OP_ISP_EN) begin
          next_r.in_system_programming = 1'b1;
        end
        if (r.ir_sh == jip_pkg::OP_ISP_DIS) begin
          next_r.in_system_programming = 1'b0;
        end
      end
      jip_pkg::S_CAP_DR: begin
        case (r.ir)
          jip_pkg::OP_DEVICE_IDENTIFICATION: begin
            next_r.dr[jip_pkg::ID_LEN-1:0] = {ID_VER, ID_PART, ID_MFR, 1'b1};
          end
          jip_pkg::OP_USER_SIGNATURE: begin
            next_r.dr[jip_pkg::ID_LEN-1:0] = USER_SIG;
          end
          jip_pkg::OP_EXTEST, jip_pkg::OP_SAMPLE: begin
            for (int p = 0; p < NPINS; p++) begin
              next_r.dr[3*p]   = r.pin_s2[p];
              next_r.dr[3*p+1] = core_out[p];
              next_r.dr[3*p+2] = core_oe[p];
            end
          end
          default: begin
            next_r.dr[0] = 1'b0;  // bypass captures zero
          end
        endcase
      end
      jip_pkg::S_SH_DR: begin
        // tdi enters at the top of the selected length, lsb leaves first
        for (int i = 0; i < BW; i++) begin
          if (i == len - 1) begin
            next_r.dr[i] = link.tdi;
          end else if (i < len - 1) begin
            next_r.dr[i] = sh[i];
          end
        end
      end
      jip_pkg::S_UPD_DR: begin
        if (r.ir == jip_pkg::OP_EXTEST) begin
          next_r.bsr = r.dr;
        end
      end
      default: begin
      end
    endcase
  end

  // state register on the link clock
  always_ff @(posedge link.tck) begin
    if (!aresetn) begin
      r <= '{st: jip_pkg::S_RESET, ir: jip_pkg::OP_DEVICE_IDENTIFICATION, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // serial out: lsb of whichever path is shifting, else low
  always_comb begin
    if (r.st == jip_pkg::S_SH_IR) begin
      link.tdo = r.ir_sh[0];
    end else if (r.st == jip_pkg::S_SH_DR) begin
      link.tdo = r.dr[0];
    end else begin
      link.tdo = 1'b0;
    end
  end

  // pin gating; extest wins over core logic but still waits for power
  always_comb begin
    logic user_ok;
    logic ext;
    user_ok = r.pg[1] && r.done && !r.in_system_programming;
    ext = r.pg[1] && !r.in_system_programming && (r.ir == jip_pkg::OP_EXTEST);
    for (int p = 0; p < NPINS; p++) begin
      pin_o[p]  = ext ? r.bsr[3*p+1] : core_out[p];
      pin_oe[p] = ext ? r.bsr[3*p+2] : (core_oe[p] && user_ok);
    end
  end

  assign pin_pullup = r.in_system_programming;
  assign prog_done  = r.done;
  assign isp_active = r.in_system_programming;
endmodule

/* hw/jip_ctl_host.sv */
// scan controller end: axi4-lite registers, link clock divider, tms walker
`timescale 1ns/1ps
module jip_ctl_host #(
  parameter int HALF = jip_pkg::TCK_HALF_CYC  // aclk cycles per tck half period
) (
  input  wire logic        aclk,     // system clock
  input  wire logic        aresetn,  // sync reset, active low
  input  wire logic [3:0]  awaddr,   // write address
  input  wire logic        awvalid,  // write address valid
  output logic             awready,  // write address ready
  input  wire logic [31:0] wdata,    // write data
  input  wire logic [3:0]  wstrb,    // write byte enables
  input  wire logic        wvalid,   // write data valid
  output logic             wready,   // write data ready
  output logic [1:0]       bresp,    // write response
  output logic             bvalid,   // write response valid
  input  wire logic        bready,   // write response ready
  input  wire logic [3:0]  araddr,   // read address
  input  wire logic        arvalid,  // read address valid
  output logic             arready,  // read address ready
  output logic [31:0]      rdata,    // read data
  output logic [1:0]       rresp,    // read response
  output logic             rvalid,   // read data valid
  input  wire logic        rready,   // read data ready
  jip_link_if.host         link      // serial test port
);
  typedef enum logic [1:0] {H_IDLE, H_PRE, H_SHIFT, H_POST} jip_walk_e;

  // whole state of the controller
  typedef struct packed {
    logic        tck;     // link clock out
    logic        tms;     // mode select out
    logic        tdi;     // serial data out
    logic [7:0]  div;     // half period counter
    jip_walk_e   fsm;     // walker phase
    logic [7:0]  pat;     // pending tms bits, lsb next
    logic [2:0]  pcnt;    // pending tms count
    logic [31:0] tx;      // bits to send
    logic [31:0] rx;      // bits received
    logic [4:0]  bitn;    // current shift bit
    logic [4:0]  len;     // last shift bit index
    logic [1:0]  kind;    // operation kind
    logic        hold;    // end in pause
    logic        cont;    // start from pause
    logic        go;      // command pending
    logic [1:0]  tdo_s;   // tdo sync
    logic        aw_got;  // write address held
    logic        w_got;   // write data held
    logic [3:0]  awa;     // held write address
    logic [31:0] wd;      // held write data
    logic [3:0]  ws;      // held byte enables
    logic        bv;      // write response valid
    logic [1:0]  br;      // write response code
    logic        rv;      // read data valid
    logic [31:0] rd;      // read data
    logic [1:0]  rr;      // read response code
  } jip_host_s;

  jip_host_s r;       // registered state
  jip_host_s next_r;  // next state

  logic busy;  // walker or command in flight
  assign busy    = r.go || (r.fsm != H_IDLE);
  assign awready = !r.aw_got && !r.bv;
  assign wready  = !r.w_got && !r.bv;
  assign arready = !r.rv;

  always_comb begin
    logic       top;
    logic [10:0] walk;
    top = (r.div == 8'(HALF - 1));
    walk = jip_pkg::WALK_RESET;
    next_r = r;
    next_r.div = top ? 8'h00 : r.div + 8'h01;
    next_r.tck = top ? !r.tck : r.tck;
    next_r.tdo_s = {r.tdo_s[0], link.tdo};

    // falling tck: present the next tms and tdi
    if (top && r.tck) begin
      case (r.fsm)
        H_IDLE: begin
          next_r.tms = 1'b0;
          next_r.tdi = 1'b0;
          if (r.go) begin
            if (r.kind == jip_pkg::KIND_RESET) walk = jip_pkg::WALK_RESET;
            else if (r.cont) walk = jip_pkg::WALK_CONT;
            else if (r.kind == jip_pkg::KIND_IR) walk = jip_pkg::WALK_IR;
            else walk = jip_pkg::WALK_DR;
            next_r.go = 1'b0;
            next_r.fsm = H_PRE;
            next_r.rx = 32'h0000_0000;
            {next_r.pcnt, next_r.pat} = walk;
            next_r.tms = walk[0];
          end
        end
        H_PRE, H_POST: begin
          next_r.tms = r.pat[0];
        end
        H_SHIFT: begin
          next_r.tms = (r.bitn == r.len);
          next_r.tdi = r.tx[r.bitn];
        end
        default: begin
        end
      endcase
    end

    // rising tck: sample tdo and step the walk
    if (top && !r.tck) begin
      case (r.fsm)
        H_PRE, H_POST: begin
          next_r.pat = {1'b0, r.pat[7:1]};
          next_r.pcnt = r.pcnt - 3'h1;
          if (r.pcnt == 3'h1) begin
            next_r.bitn = 5'h00;
            next_r.fsm = (r.fsm == H_PRE && r.kind != jip_pkg::KIND_RESET) ? H_SHIFT : H_IDLE;
          end
        end
        H_SHIFT: begin
          next_r.rx[r.bitn] = r.tdo_s[1];
          if (r.bitn == r.len) begin
            next_r.fsm = H_POST;
            {next_r.pcnt, next_r.pat} = r.hold ? jip_pkg::WALK_HOLD : jip_pkg::WALK_DONE;
          end else begin
            next_r.bitn = r.bitn + 5'h01;
          end
        end
        default: begin
        end
      endcase
    end

    // write channels taken in either order
    if (awvalid && awready) begin
      next_r.aw_got = 1'b1;
      next_r.awa = awaddr;
    end
    if (wvalid && wready) begin
      next_r.w_got = 1'b1;
      next_r.wd = wdata;
      next_r.ws = wstrb;
    end
    if (r.aw_got && r.w_got && !r.bv) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bv = 1'b1;
      next_r.br = jip_pkg::RESP_OKAY;
      // a busy walker must not see its command or data change
      if (busy && (r.awa == jip_pkg::REG_CTRL || r.awa == jip_pkg::REG_TX)) begin
        next_r.br = jip_pkg::RESP_SLVERR;
      end else if (r.awa == jip_pkg::REG_CTRL) begin
        next_r.kind = r.wd[jip_pkg::CTL_KIND +: 2];
        next_r.len = r.wd[jip_pkg::CTL_LEN +: 5];
        next_r.hold = r.wd[jip_pkg::CTL_HOLD];
        next_r.cont = r.wd[jip_pkg::CTL_CONT];
        next_r.go = 1'b1;
      end else if (r.awa == jip_pkg::REG_TX) begin
        for (int b = 0; b < 4; b++) begin
          if (r.ws[b]) next_r.tx[8*b +: 8] = r.wd[8*b +: 8];
        end
      end else begin
        next_r.br = jip_pkg::RESP_SLVERR;
      end
    end
    if (r.bv && bready) next_r.bv = 1'b0;

    // read channel
    if (arvalid && arready) begin
      next_r.rv = 1'b1;
      next_r.rr = jip_pkg::RESP_OKAY;
      case (araddr)
        jip_pkg::REG_CTRL: next_r.rd = {23'h0, r.cont, r.hold, r.len, r.kind};
        jip_pkg::REG_STAT: next_r.rd = {31'h0, busy};
        jip_pkg::REG_TX:   next_r.rd = r.tx;
        jip_pkg::REG_RX:   next_r.rd = r.rx;
        default: begin
          next_r.rd = 32'h0000_0000;
          next_r.rr = jip_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (r.rv && rready) next_r.rv = 1'b0;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{fsm: H_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.tck = r.tck;
  assign link.tms = r.tms;
  assign link.tdi = r.tdi;
  assign bvalid   = r.bv;
  assign bresp    = r.br;
  assign rvalid   = r.rv;
  assign rdata    = r.rd;
  assign rresp    = r.rr;
endmodule

/* bench/jip_link_monitor.sv */
// checker of the scan link and the device pin gating
`timescale 1ns/1ps
module jip_link_monitor (
  input wire logic        tck,         // link clock
  input wire logic        tms,         // mode select
  input wire logic        tdi,         // serial into device
  input wire logic        tdo,         // serial out of device
  input wire logic        aresetn,     // device reset, tck domain
  input wire logic        power_good,  // supplies in range
  input wire logic [63:0] pin_oe,      // pin drive enables
  input wire logic        pin_pullup,  // weak pull-ups
  input wire logic        isp_active,  // programming mode
  input wire logic        prog_done    // done flag
);
  // next tap state, one nibble per state, for tms low and tms high
  localparam logic [63:0] N0 = 64'h1bddbba1_46644311;
  localparam logic [63:0] N1 = 64'h2fefcc02_87855920;
  logic [3:0] st;   // tap state rebuilt from tms
  logic [7:0] run;  // shift-ir edges in a row
  // tracking the tap from tms alone, so no device state is trusted
  always_ff @(posedge tck) begin
    st  <= !aresetn ? 4'h0 : (tms ? N1[st*4+:4] : N0[st*4+:4]);
    run <= (aresetn && st == 4'hb) ? run + 8'h01 : 8'h00;
  end
  default clocking @(posedge tck); endclocking
  default disable iff (!aresetn);
  a_isp_pins_off: assert property (isp_active |-> pin_oe == 64'h0)
    else $error("pin driven while programming");
  a_isp_pullup: assert property (pin_pullup == isp_active)
    else $error("pull-ups differ from programming mode");
  a_power_pins_off: assert property (!power_good [*3] |-> pin_oe == 64'h0)
    else $error("pin driven without power");
  a_done_change: assert property ($changed(prog_done) |-> $past(st) == 4'h1 && $past(isp_active))
    else $error("done flag moved outside programming idle");
  a_isp_update: assert property ($changed(isp_active) |-> $past(st) inside {4'h0, 4'hf})
    else $error("programming mode moved outside update");
  a_tdo_quiet: assert property (!(st inside {4'h4, 4'hb}) |-> !tdo)
    else $error("serial out active outside shift");
  a_ir_capture: assert property (st == 4'ha |=> tdo ##1 !tdo)
    else $error("instruction capture pattern wrong");
  a_ir_length: assert property (st == 4'hb && run >= 8'd10 |-> tdo == $past(tdi, 10))
    else $error("instruction path length wrong");
  // main scenarios reached
  c_isp: cover property ($rose(isp_active));
  c_done: cover property ($rose(prog_done));
  c_long_ir: cover property (st == 4'hb && run >= 8'd10);
endmodule

/* bench/tb.sv */
// testbench: controller and device joined over the scan link
`timescale 1ns/1ps
module tb;
  localparam logic [3:0]  VER  = 4'h3;                   // arbitrary value
  localparam logic [15:0] PART = 16'h1e2d;               // arbitrary value
  localparam logic [10:0] MFR  = 11'h155;                // arbitrary value
  localparam logic [31:0] SIG  = 32'h6a5c_3e01;          // user signature
  localparam logic [31:0] IDW  = {VER, PART, MFR, 1'b1}; // expected id word
  localparam logic [63:0] PIN  = 64'h0f1e_2d3c_4b5a_6978; // board pin levels
  localparam logic [63:0] CO   = 64'hc3a5_5a3c_0ff0_9669; // core values
  localparam logic [63:0] CE   = 64'hffff_0000_f0f0_3c3c; // core enables
  logic        aclk, aresetn, dev_aresetn, power_good;    // clocks and resets
  logic [3:0]  awaddr, araddr, wstrb;                     // bus address, strobes
  logic        awvalid, wvalid, bready, arvalid, rready;  // bus requests
  logic        awready, wready, bvalid, arready, rvalid;  // bus answers
  logic [31:0] wdata, rdata;                              // bus data
  logic [1:0]  bresp, rresp;                              // bus responses
  logic [63:0] core_out, core_oe, pin_i, pin_o, pin_oe;   // pins
  logic        pin_pullup, prog_done, isp_active;         // device status
  int          n_errors, n_checks;                        // tallies
  jip_link_if link();
  jip_ctl_host u_jip_ctl_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
  jip_scan_dev #(.ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR), .USER_SIG(SIG)) u_jip_scan_dev (
    .link(link), .aresetn(dev_aresetn), .power_good(power_good), .core_out(core_out), .core_oe(core_oe),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .prog_done(prog_done),
    .isp_active(isp_active));
  jip_link_monitor u_jip_link_monitor (.tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo),
    .aresetn(dev_aresetn), .power_good(power_good), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .isp_active(isp_active), .prog_done(prog_done));
  // system clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // verdict and end of run
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare one value exactly, an unknown matches only an unknown
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // bus write; address and data each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  // bus read
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  function automatic logic [31:0] cmd(input logic [1:0] k, input int n, input logic h, input logic c);
    return {23'h0, c, h, 5'(n - 1), k};
  endfunction
  // start a walk, optionally try refused writes while busy, then fetch what came back
  task automatic go(input logic [31:0] c, input logic refuse, output logic [31:0] rx);
    logic [1:0] r;
    wr(jip_pkg::REG_CTRL, c, jip_pkg::RESP_OKAY);
    if (refuse) begin
      wr(jip_pkg::REG_CTRL, c, jip_pkg::RESP_SLVERR);
      wr(jip_pkg::REG_TX, 32'hffff_ffff, jip_pkg::RESP_SLVERR);
    end
    do rd(jip_pkg::REG_STAT, rx, r); while (rx[0] !== 1'b0);
    rd(jip_pkg::REG_RX, rx, r);
  endtask
  task automatic shift(input logic [31:0] c, input logic [31:0] tx, output logic [31:0] rx);
    wr(jip_pkg::REG_TX, tx, jip_pkg::RESP_OKAY);
    go(c, 1'b0, rx);
  endtask
  task automatic ir(input logic [9:0] op);
    logic [31:0] rx;
    shift(cmd(jip_pkg::KIND_IR, 10, 1'b0, 1'b0), {22'h0, op}, rx);
  endtask
  // wait for the done flag under a bound
  task automatic wait_done(input logic v);
    int k;
    for (k = 0; k < 200 && prog_done !== v; k++) @(posedge aclk);
  endtask
  // hang guard
  initial begin
    #900_000;
    n_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    logic [31:0] rx;
    logic [1:0]  r;
    int          k, j;
    {aresetn, dev_aresetn, power_good, awvalid, wvalid, bready, arvalid, rready} = 8'h0;
    {awaddr, araddr, wdata, wstrb} = {8'h0, 32'h0, 4'hf};
    {core_out, core_oe, pin_i} = {CO, CE, PIN};
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
    chk({prog_done, isp_active, pin_pullup, pin_oe}, 67'h0);
    // device side levels launched on an aclk rise, seen at a later tck rise
    @(posedge aclk);
    dev_aresetn <= 1'b1;
    power_good <= 1'b1;
    rd(jip_pkg::REG_STAT, rx, r);
    chk(rx, 32'h0);
    wr(jip_pkg::REG_STAT, 32'h1, jip_pkg::RESP_SLVERR);
    rd(4'h6, rx, r);
    chk({r, rx}, {jip_pkg::RESP_SLVERR, 32'h0});
    go(cmd(jip_pkg::KIND_RESET, 1, 1'b0, 1'b0), 1'b0, rx);
    shift(cmd(jip_pkg::KIND_DR, 32, 1'b0, 1'b0), 32'h0, rx);
    chk(rx, IDW);
    shift(cmd(jip_pkg::KIND_IR, 20, 1'b0, 1'b0), {12'h0, jip_pkg::OP_USER_SIGNATURE, 10'h155}, rx);
    chk(rx[19:0], {10'h155, jip_pkg::IR_CAPTURE});
    shift(cmd(jip_pkg::KIND_DR, 32, 1'b0, 1'b0), 32'h0, rx);
    chk(rx, SIG);
    ir(jip_pkg::OP_DEVICE_IDENTIFICATION);
    go(cmd(jip_pkg::KIND_DR, 32, 1'b0, 1'b0), 1'b1, rx);
    chk(rx, IDW);
    ir(jip_pkg::OP_BYPASS);
    shift(cmd(jip_pkg::KIND_DR, 8, 1'b0, 1'b0), 32'ha5, rx);
    chk(rx[7:0], 8'h4a);
    // six held chunks cover the chain; a seventh returns the first chunk
    ir(jip_pkg::OP_SAMPLE);
    for (k = 0; k < 7; k++) begin
      shift(cmd(jip_pkg::KIND_DR, 32, k < 6, k > 0), 32'h9e37_0000 | 32'(k), rx);
      for (j = 0; j < 32; j++)
        if (k < 6 && (32 * k + j) % 3 == 0) chk(rx[j], pin_i[(32 * k + j) / 3]);
      if (k == 6) chk(rx, 32'h9e37_0000);
    end
    ir(jip_pkg::OP_ISP_EN);
    chk({isp_active, pin_pullup, pin_oe}, {2'b11, 64'h0});
    ir(jip_pkg::OP_PROGRAMMING_COMPLETE_FLAG);
    wait_done(1'b1);
    ir(jip_pkg::OP_ISP_DIS);
    chk({prog_done, isp_active, pin_pullup}, 3'b100);
    chk(pin_oe, CE);
    chk(pin_o, CO);
    @(posedge aclk);
    power_good <= 1'b0;
    repeat (60) @(posedge aclk);
    chk(pin_oe, 64'h0);
    @(posedge aclk);
    power_good <= 1'b1;
    // boundary update cells still clear, so extest takes the pins off the core
    ir(jip_pkg::OP_EXTEST);
    chk(pin_oe, 64'h0);
    chk(pin_o, 64'h0);
    ir(jip_pkg::OP_ISP_EN);
    ir(jip_pkg::OP_ISP_ERA);
    wait_done(1'b0);
    ir(jip_pkg::OP_ISP_DIS);
    chk({prog_done, isp_active, pin_oe}, 66'h0);
    stop_test();
  end
endmodule
